/* File: design/msc_pkg.sv */
// constants, types and register map of the mode select and power state controller
// assumes a single 40 MHz system clock and an APB master with 32-bit data
//
// Contract
// - after reset, enter mode select and latch both straps
// - enable low: NORMAL; enable high: straps 11 NORMAL, 00 test (code gives restricted NORMAL for straps 11)
// - straps a0 b1: PROGRAMMING if unlocked, else restricted NORMAL
// - straps a1 b0: DEBUG, writes disabled, if unlocked, else restricted NORMAL
// - after the window, run in the decoded mode
// - INIT resets registers, starts code at 4000 hex, goes RUN
// - INIT after NORMAL decode, power-down exit, watchdog reset
// - RUN: watchdog on; wake events set flags only
// - RUN: wake pin levels shown in port input registers
// - IDLE: CPU clock gated, peripherals run
// - resume event in IDLE returns to RUN at once
// - watchdog on in IDLE, cleared on entry
// - IDLE: wake events set flags only
// - IDLE interrupt runs handler; return to IDLE unless resumed
// - resume flags record the seven resume sources
// - IDLE accepts interrupts from ten sources
// - POWER DOWN cuts CPU and peripheral power, keeps controller
// - wake flags cleared on POWER DOWN entry
// - POWER DOWN: receiver powered periodically if timer enabled
// - pin, interval, carrier, pattern, sync wake POWER DOWN, flagged
// - config register zero bit 5 requests IDLE
// - POWER DOWN only by software, config register zero bit 7
// - IDLE request ignored with no resume source active
// - POWER DOWN wake goes INIT, flags source, re-inits watchdog
package msc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_CONFIG_REG_ZERO    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RESUME  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WAKE    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EXTWAKE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PORT1   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PORT3   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EXTCFG  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PERIPH  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_LFTIMER = 8'h24;

  localparam int CONFIG_REG_ZERO_IDLE_BIT = 5;
  localparam int CONFIG_REG_ZERO_POWER_DOWN_STATE_BIT = 7;

  localparam int RESUME_W  = 7;
  localparam int IRQ_W     = 10;
  localparam int EXTWAKE_W = 8;
  localparam int PORT_W    = 4;
  localparam int WAKE_W    = 5;
  localparam int PIN_W     = 4 + EXTWAKE_W;

  // pin vector layout
  localparam int PIN_TME   = 0;
  localparam int PIN_MSE   = 1;
  localparam int PIN_STRAPA = 2;
  localparam int PIN_STRAPB = 3;
  localparam int PIN_EXT_LSB = 4;

  // wake flag bits
  localparam int WAKE_INTERVAL = 0;
  localparam int WAKE_CARRIER  = 1;
  localparam int WAKE_PATTERN  = 2;
  localparam int WAKE_SYNC     = 3;
  localparam int WAKE_WDG      = 4;

  // status fields
  localparam int STAT_STATE_LSB    = 0;
  localparam int STAT_MODE_LSB     = 4;
  localparam int STAT_RESTRICT_BIT = 8;
  localparam int STAT_DISABLE_BIT  = 9;

  // peripheral control fields
  localparam int PERIPH_LFT_BIT = 8;
  localparam int PERIPH_RAM_BIT = 9;
  localparam int EXTCFG_EN_LSB  = 8;
  localparam int LFT_ON_LSB     = 16;
  localparam int LFT_CNT_W      = 16;

  localparam logic [DATA_W-1:0] PERIPH_RST  = 32'h0000_007F;
  localparam logic [DATA_W-1:0] EXTCFG_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] LFTIMER_RST = 32'h0010_1000;

  localparam logic [15:0] CPU_START_ADDR = 16'h4000;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PROGRAMMING,
    MODE_DEBUG,
    MODE_TEST
  } mscMode_t;

  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_INIT,
    ST_RUN,
    ST_IDLE,
    ST_ISR,
    ST_POWER_DOWN,
    ST_HANDLER
  } mscState_t;

  typedef struct packed {
    logic cpuClkEn;
    logic cpuPowerEn;
    logic periphPowerEn;
    logic ramPowerEn;
  } mscPower_t;

endpackage

/* File: design/mode_select_power_state_ctrl.sv */
// mode select after reset and NORMAL mode power state sequencing, APB registers
// assumes straps and wake pins are asynchronous; events and lock byte are on sys_clk
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module mode_select_power_state_ctrl
  import msc_pkg::*;
#(
  parameter int MODE_WINDOW_CYCLES = 64
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [DATA_W-1:0]    pwdata,
  output logic      [DATA_W-1:0]    prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 test_mode_enable_pin,
  input  wire logic                 mode_select_enable_pin,
  input  wire logic                 mode_strap_a,
  input  wire logic                 mode_strap_b,
  input  wire logic                 lockByteSet,
  input  wire logic [EXTWAKE_W-1:0] extWakePin,
  input  wire logic [RESUME_W-1:0]  resumeEvent,
  input  wire logic [IRQ_W-1:0]     irqRequest,
  input  wire logic                 return_from_interrupt,
  input  wire logic                 watchdogElapsed,
  input  wire logic                 intervalTimerUnderflow,
  input  wire logic                 lfCarrierDetect,
  input  wire logic                 lfPatternMatch,
  input  wire logic                 lfSyncMatch,
  output mscMode_t                  opMode,
  output mscState_t                 ctrlState,
  output mscPower_t                 powerCtl,
  output logic                      sfrInitPulse,
  output logic                      cpuStartPulse,
  output logic      [15:0]          cpuStartAddr,
  output logic                      watchdogEnable,
  output logic                      watchdogClear,
  output logic                      lfRxPowerOn,
  output logic                      flashWriteRestrict,
  output logic                      flashWriteDisable
);

  localparam int WIN_W = $clog2(MODE_WINDOW_CYCLES + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(MODE_WINDOW_CYCLES - 1);

  logic [PIN_W-1:0]     pinRaw;
  logic [PIN_W-1:0]     pinS1_q;
  logic [PIN_W-1:0]     pinS2_q;
  logic [PIN_W-1:0]     pinS3_q;
  logic [PIN_W-1:0]     pinStable_q;
  logic [WIN_W-1:0]     winCnt_q;
  logic                 winDone;
  mscMode_t             decMode;
  logic                 decRestrict;
  logic                 decDisable;
  mscState_t            state_q;
  mscState_t            state_d;
  logic                 idleReq_q;
  logic                 pdwnReq_q;
  logic                 resumeSeen_q;
  logic [RESUME_W-1:0]  resumeFlag_q;
  logic [WAKE_W-1:0]    wakeFlag_q;
  logic [EXTWAKE_W-1:0] extFlag_q;
  logic [WAKE_W-1:0]    wakeSet;
  logic [EXTWAKE_W-1:0] extMatch;
  logic [EXTWAKE_W-1:0] extMatch_q;
  logic [EXTWAKE_W-1:0] extRise;
  logic [PORT_W-1:0]    portOne_q;
  logic [PORT_W-1:0]    portThree_q;
  logic [DATA_W-1:0]    extCfg_q;
  logic [DATA_W-1:0]    periph_q;
  logic [DATA_W-1:0]    lfTimer_q;
  logic [LFT_CNT_W-1:0] lfCnt_q;
  logic                 anyResume;
  logic                 anyIrq;
  logic                 wdgHit;
  logic                 wakeHit;
  logic                 pdwnEntry;
  logic                 apbSetup;
  logic                 apbWrite;
  logic                 mapped;
  logic [DATA_W-1:0]    rdata;

  // three-stage pin sync, taken when stages two and three agree
  assign pinRaw = {extWakePin, mode_strap_b, mode_strap_a, mode_select_enable_pin, test_mode_enable_pin};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
    end
    else
    begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  for (genvar i = 0; i < PIN_W; i++)
  begin : g_pinFilter
    always_ff @(posedge sys_clk)
    begin
      if (reset)
        pinStable_q[i] <= 1'b0;
      else if (pinS2_q[i] == pinS3_q[i])
        pinStable_q[i] <= pinS3_q[i];
    end
  end

  // mode sample window
  assign winDone = (state_q == ST_SAMPLE) && (winCnt_q == WIN_LAST);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      winCnt_q <= '0;
    else if (state_q == ST_SAMPLE && !winDone)
      winCnt_q <= winCnt_q + WIN_W'(1);
  end

  // strap decode on the levels held at the window end
  always_comb
  begin
    decMode     = MODE_NORMAL;
    decRestrict = lockByteSet;
    decDisable  = 1'b0;
    if (pinStable_q[PIN_TME])
      decMode = MODE_TEST;
    else if (pinStable_q[PIN_MSE])
    begin
      case ({pinStable_q[PIN_STRAPA], pinStable_q[PIN_STRAPB]})
        2'h0: decMode = MODE_TEST;
        2'h1:
        begin
          decMode     = lockByteSet ? MODE_NORMAL : MODE_PROGRAMMING;
          decRestrict = lockByteSet;
        end
        2'h2:
        begin
          decMode     = lockByteSet ? MODE_NORMAL : MODE_DEBUG;
          decRestrict = lockByteSet;
          decDisable  = !lockByteSet;
        end
        default: decRestrict = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      opMode             <= MODE_NORMAL;
      flashWriteRestrict <= 1'b0;
      flashWriteDisable  <= 1'b0;
    end
    else if (winDone)
    begin
      opMode             <= decMode;
      flashWriteRestrict <= decRestrict;
      flashWriteDisable  <= decDisable;
    end
  end

  // event summaries
  assign anyResume = |(resumeEvent & periph_q[RESUME_W-1:0]);
  assign anyIrq    = |irqRequest;
  assign wdgHit    = watchdogElapsed && (state_q == ST_RUN || state_q == ST_IDLE || state_q == ST_ISR);

  for (genvar i = 0; i < EXTWAKE_W; i++)
  begin : g_extMatch
    assign extMatch[i] = extCfg_q[EXTCFG_EN_LSB+i] && (pinStable_q[PIN_EXT_LSB+i] == extCfg_q[i]);
  end

  assign extRise = extMatch & ~extMatch_q;
  assign wakeSet = {wdgHit, lfSyncMatch, lfPatternMatch, lfCarrierDetect, intervalTimerUnderflow};
  assign wakeHit = (|extRise) || (|wakeSet[WAKE_SYNC:WAKE_INTERVAL]);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      extMatch_q <= '0;
    else
      extMatch_q <= extMatch;
  end

  // power state sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_SAMPLE:
        if (winDone)
          state_d = (decMode == MODE_NORMAL) ? ST_INIT : ST_HANDLER;
      ST_INIT:
        state_d = ST_RUN;
      ST_RUN:
        if (wdgHit)
          state_d = ST_INIT;
        else if (pdwnReq_q)
          state_d = ST_POWER_DOWN;
        else if (idleReq_q && |periph_q[RESUME_W-1:0])
          state_d = ST_IDLE;
      ST_IDLE:
        if (wdgHit)
          state_d = ST_INIT;
        else if (anyResume)
          state_d = ST_RUN;
        else if (anyIrq)
          state_d = ST_ISR;
      ST_ISR:
        if (wdgHit)
          state_d = ST_INIT;
        else if (return_from_interrupt)
          state_d = (resumeSeen_q || anyResume) ? ST_RUN : ST_IDLE;
      ST_POWER_DOWN:
        if (wakeHit)
          state_d = ST_INIT;
      ST_HANDLER:
        state_d = ST_HANDLER;
      default:
        state_d = ST_SAMPLE;
    endcase
  end

  assign pdwnEntry = (state_d == ST_POWER_DOWN) && (state_q != ST_POWER_DOWN);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      state_q <= ST_SAMPLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      resumeSeen_q <= 1'b0;
    else if (state_q != ST_ISR)
      resumeSeen_q <= 1'b0;
    else if (anyResume)
      resumeSeen_q <= 1'b1;
  end

  // registered controls toward core, watchdog and supplies
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrlState      <= ST_SAMPLE;
      powerCtl       <= '0;
      sfrInitPulse   <= 1'b0;
      cpuStartPulse  <= 1'b0;
      cpuStartAddr   <= CPU_START_ADDR;
      watchdogEnable <= 1'b0;
      watchdogClear  <= 1'b0;
    end
    else
    begin
      ctrlState              <= state_d;
      powerCtl.cpuClkEn      <= state_d == ST_INIT || state_d == ST_RUN || state_d == ST_ISR;
      powerCtl.cpuPowerEn    <= state_d != ST_POWER_DOWN && state_d != ST_SAMPLE;
      powerCtl.periphPowerEn <= state_d != ST_POWER_DOWN && state_d != ST_SAMPLE;
      powerCtl.ramPowerEn    <= state_d != ST_POWER_DOWN || periph_q[PERIPH_RAM_BIT];
      sfrInitPulse           <= state_d == ST_INIT;
      cpuStartPulse          <= state_q == ST_INIT;
      cpuStartAddr           <= CPU_START_ADDR;
      watchdogEnable         <= state_d == ST_RUN || state_d == ST_IDLE || state_d == ST_ISR;
      watchdogClear          <= (state_d == ST_IDLE && state_q != ST_IDLE) || state_d == ST_INIT;
    end
  end

  // software requests, taken once and then dropped
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      idleReq_q <= 1'b0;
      pdwnReq_q <= 1'b0;
    end
    else if (apbWrite && paddr == OFS_CONFIG_REG_ZERO)
    begin
      idleReq_q <= pwdata[CONFIG_REG_ZERO_IDLE_BIT];
      pdwnReq_q <= pwdata[CONFIG_REG_ZERO_POWER_DOWN_STATE_BIT];
    end
    else
    begin
      idleReq_q <= 1'b0;
      pdwnReq_q <= 1'b0;
    end
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      resumeFlag_q <= '0;
    else
      resumeFlag_q <= (resumeFlag_q & ~((apbWrite && paddr == OFS_RESUME) ? pwdata[RESUME_W-1:0] : '0))
                      | resumeEvent;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wakeFlag_q <= '0;
    else
      wakeFlag_q <= (wakeFlag_q & ~((apbWrite && paddr == OFS_WAKE) ? pwdata[WAKE_W-1:0] : '0)
                     & ~{WAKE_W{pdwnEntry}}) | wakeSet;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      extFlag_q <= '0;
    else
      extFlag_q <= (extFlag_q & ~((apbWrite && paddr == OFS_EXTWAKE) ? pwdata[EXTWAKE_W-1:0] : '0)
                    & ~{EXTWAKE_W{pdwnEntry}}) | extRise;
  end

  // port input mirrors, follow the pins only in RUN
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      portOne_q   <= '0;
      portThree_q <= '0;
    end
    else if (state_q == ST_RUN)
    begin
      portOne_q   <= pinStable_q[PIN_EXT_LSB +: PORT_W];
      portThree_q <= pinStable_q[PIN_EXT_LSB+PORT_W +: PORT_W];
    end
  end

  // periodic receiver power in POWER DOWN
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      lfCnt_q     <= '0;
      lfRxPowerOn <= 1'b0;
    end
    else if (state_q != ST_POWER_DOWN || !periph_q[PERIPH_LFT_BIT])
    begin
      lfCnt_q     <= '0;
      lfRxPowerOn <= 1'b0;
    end
    else if (!lfRxPowerOn && lfCnt_q >= lfTimer_q[LFT_CNT_W-1:0])
    begin
      lfCnt_q     <= '0;
      lfRxPowerOn <= 1'b1;
    end
    else if (lfRxPowerOn && lfCnt_q >= lfTimer_q[LFT_ON_LSB +: LFT_CNT_W])
    begin
      lfCnt_q     <= '0;
      lfRxPowerOn <= 1'b0;
    end
    else
      lfCnt_q <= lfCnt_q + LFT_CNT_W'(1);
  end

  // APB slave, answers in the first access cycle
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite && mapped;

  always_comb
  begin
    mapped = 1'b1;
    rdata  = '0;
    case (paddr)
      OFS_CONFIG_REG_ZERO:
      begin
        rdata[CONFIG_REG_ZERO_IDLE_BIT] = idleReq_q;
        rdata[CONFIG_REG_ZERO_POWER_DOWN_STATE_BIT] = pdwnReq_q;
      end
      OFS_STATUS:
      begin
        rdata[STAT_STATE_LSB +: 3] = state_q;
        rdata[STAT_MODE_LSB +: 2]  = opMode;
        rdata[STAT_RESTRICT_BIT]   = flashWriteRestrict;
        rdata[STAT_DISABLE_BIT]    = flashWriteDisable;
      end
      OFS_RESUME:  rdata[RESUME_W-1:0]  = resumeFlag_q;
      OFS_WAKE:    rdata[WAKE_W-1:0]    = wakeFlag_q;
      OFS_EXTWAKE: rdata[EXTWAKE_W-1:0] = extFlag_q;
      OFS_PORT1:   rdata[PORT_W-1:0]    = portOne_q;
      OFS_PORT3:   rdata[PORT_W-1:0]    = portThree_q;
      OFS_EXTCFG:  rdata                = extCfg_q;
      OFS_PERIPH:  rdata                = periph_q;
      OFS_LFTIMER: rdata                = lfTimer_q;
      default:     mapped               = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= apbSetup;
      pslverr <= apbSetup && !mapped;
      prdata  <= apbSetup ? rdata : '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      extCfg_q  <= EXTCFG_RST;
      periph_q  <= PERIPH_RST;
      lfTimer_q <= LFTIMER_RST;
    end
    else if (apbWrite)
    begin
      if (paddr == OFS_EXTCFG)
        extCfg_q <= pwdata;
      if (paddr == OFS_PERIPH)
        periph_q <= pwdata;
      if (paddr == OFS_LFTIMER)
        lfTimer_q <= pwdata;
    end
  end

endmodule

/* File: bench/msc_props.sv */
// concurrent checks on the mode select and power state controller ports
// assumes it is bound into every instance of the controller
`timescale 1ns/1ps
module msc_props
  import msc_pkg::*;
#(
  parameter int MODE_WINDOW_CYCLES = 64
)
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [6:0]  resumeEvent,
  input wire logic [9:0]  irqRequest,
  input wire logic        watchdogElapsed,
  input mscMode_t         opMode,
  input mscState_t        ctrlState,
  input mscPower_t        powerCtl,
  input wire logic        sfrInitPulse,
  input wire logic        cpuStartPulse,
  input wire logic [15:0] cpuStartAddr,
  input wire logic        watchdogEnable,
  input wire logic        watchdogClear,
  input wire logic        flashWriteRestrict,
  input wire logic        flashWriteDisable
);
  logic [15:0] sampCnt_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sampCnt_q <= 16'h0000;
    else if (ctrlState == ST_SAMPLE)
      sampCnt_q <= sampCnt_q + 16'h0001;
  end

  AST_WINDOW_LEN: assert property ($changed(ctrlState) && $past(ctrlState) == ST_SAMPLE |->
    sampCnt_q >= MODE_WINDOW_CYCLES - 1 && sampCnt_q <= MODE_WINDOW_CYCLES + 1)
    else $error("sample window length wrong");
  AST_DECODED_START: assert property ($changed(ctrlState) && $past(ctrlState) == ST_SAMPLE |->
    (opMode == MODE_NORMAL) == (ctrlState == ST_INIT))
    else $error("mode and first state disagree");
  AST_INIT_RUN: assert property (ctrlState == ST_INIT |-> sfrInitPulse ##1
    (ctrlState == ST_RUN && cpuStartPulse && cpuStartAddr == CPU_START_ADDR))
    else $error("init did not start code");
  AST_WDG_ON: assert property (ctrlState inside {ST_RUN, ST_IDLE} |-> watchdogEnable)
    else $error("watchdog off");
  AST_WDG_CLR: assert property (ctrlState == ST_IDLE && $past(ctrlState) != ST_IDLE |-> watchdogClear)
    else $error("no idle watchdog clear");
  AST_IDLE_PWR: assert property (ctrlState == ST_IDLE |-> !powerCtl.cpuClkEn && powerCtl.periphPowerEn)
    else $error("idle power wrong");
  AST_PD_PWR: assert property (ctrlState == ST_POWER_DOWN |-> !powerCtl.cpuPowerEn && !powerCtl.periphPowerEn)
    else $error("power down power wrong");
  AST_RESUME: assert property (ctrlState == ST_IDLE && |resumeEvent && !(|irqRequest) && !watchdogElapsed
    |-> ##[1:2] ctrlState == ST_RUN)
    else $error("resume did not reach run");
  AST_PD_ENTRY: assert property (ctrlState == ST_POWER_DOWN && $past(ctrlState) != ST_POWER_DOWN |->
    $past(ctrlState) == ST_RUN)
    else $error("bad power down entry");
  AST_PD_EXIT: assert property ($past(ctrlState) == ST_POWER_DOWN && ctrlState != ST_POWER_DOWN |->
    ctrlState == ST_INIT)
    else $error("power down left without init");
  AST_DEBUG_LOCK: assert property (opMode == MODE_DEBUG |-> flashWriteDisable && !flashWriteRestrict)
    else $error("debug flash not disabled");
  AST_WDG_RESET: assert property (ctrlState inside {ST_RUN, ST_IDLE} && watchdogElapsed |->
    ##[1:2] ctrlState == ST_INIT)
    else $error("watchdog did not restart");

  COV_IDLE: cover property (ctrlState == ST_IDLE ##1 ctrlState == ST_ISR);
  COV_PD: cover property (ctrlState == ST_POWER_DOWN ##1 ctrlState == ST_INIT);
  COV_HANDLER: cover property (ctrlState == ST_HANDLER);
endmodule

bind mode_select_power_state_ctrl msc_props #(.MODE_WINDOW_CYCLES(MODE_WINDOW_CYCLES)) props_i (.*);

/* File: bench/msc_strap_model.sv */
// strap pins, external wake pins and receiver wake sources
// assumes commands from the bench; straps follow them only while reset is high
`timescale 1ns/1ps
module msc_strap_model
  import msc_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic [3:0]           strapSet,
  input  wire logic [EXTWAKE_W-1:0] extLevel,
  input  wire logic [3:0]           wakeReq,
  output logic                      test_mode_enable_pin,
  output logic                      mode_select_enable_pin,
  output logic                      mode_strap_a,
  output logic                      mode_strap_b,
  output logic      [EXTWAKE_W-1:0] extWakePin,
  output logic                      intervalTimerUnderflow,
  output logic                      lfCarrierDetect,
  output logic                      lfPatternMatch,
  output logic                      lfSyncMatch
);
  always @(posedge sys_clk)
  begin
    if (reset)
      {test_mode_enable_pin, mode_select_enable_pin, mode_strap_a, mode_strap_b} <= strapSet;
    extWakePin <= extLevel;
    {lfSyncMatch, lfPatternMatch, lfCarrierDetect, intervalTimerUnderflow} <= wakeReq;
  end
endmodule

/* File: bench/mode_select_power_state_ctrl_bench.sv */
// self-checking bench for the mode select and power state controller
// assumes the strap model drives pins and wake sources; APB driven here
`timescale 1ns/1ps
module mode_select_power_state_ctrl_bench;
  import msc_pkg::*;
  localparam int WIN = 8;
  typedef struct packed {
    logic [4:0] pins;
    mscMode_t   mode;
    logic       restr;
    logic       dis;
  } mscRow_t;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, lockByteSet;
  logic return_from_interrupt, watchdogElapsed, sfrInitPulse, cpuStartPulse;
  logic watchdogEnable, watchdogClear, lfRxPowerOn, flashWriteRestrict, flashWriteDisable;
  logic test_mode_enable_pin, mode_select_enable_pin, mode_strap_a, mode_strap_b;
  logic intervalTimerUnderflow, lfCarrierDetect, lfPatternMatch, lfSyncMatch;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata, prdata, rd;
  logic [EXTWAKE_W-1:0] extWakePin, extLevel;
  logic [RESUME_W-1:0]  resumeEvent;
  logic [IRQ_W-1:0]     irqRequest;
  logic [15:0]          cpuStartAddr;
  logic [3:0]           strapSet, wakeReq;
  logic                 err, lfSeen;
  mscMode_t             opMode;
  mscState_t            ctrlState;
  mscPower_t            powerCtl;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  // pins: enable test, enable select, strap a, strap b, lock byte
  mscRow_t rows [9] = '{
    '{5'h00, MODE_NORMAL, 1'h0, 1'h0}, '{5'h05, MODE_NORMAL, 1'h1, 1'h0},
    '{5'h08, MODE_TEST, 1'h0, 1'h0}, '{5'h0A, MODE_PROGRAMMING, 1'h0, 1'h0},
    '{5'h0B, MODE_NORMAL, 1'h1, 1'h0}, '{5'h0C, MODE_DEBUG, 1'h0, 1'h1},
    '{5'h0D, MODE_NORMAL, 1'h1, 1'h0}, '{5'h0E, MODE_NORMAL, 1'h1, 1'h0},
    '{5'h10, MODE_TEST, 1'h0, 1'h0}};

  mode_select_power_state_ctrl #(.MODE_WINDOW_CYCLES(WIN)) DUT (.*);
  msc_strap_model model_i (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (n = 0; n < 16 && pready !== 1'b1; n++)
      @(posedge sys_clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
      chk("pready", 1, 0);
  endtask

  task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] mask);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd & mask);
  endtask

  task automatic waitState(input mscState_t st);
    int n;
    for (n = 0; n < 64 && ctrlState !== st; n++)
      @(posedge sys_clk);
    chk("ctrlState", st, ctrlState);
  endtask

  task automatic boot(input logic [4:0] p);
    @(posedge sys_clk);
    reset       <= 1'b1;
    strapSet    <= p[4:1];
    lockByteSet <= p[0];
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("ctrlState in reset", ST_SAMPLE, ctrlState);
    chk("pready in reset", 0, pready);
    @(posedge sys_clk);
    reset <= 1'b0;
  endtask

  initial
  begin
    {reset, psel, penable, pwrite, lockByteSet, return_from_interrupt, watchdogElapsed} = 7'h40;
    {paddr, pwdata} = '0;
    {resumeEvent, irqRequest, strapSet, wakeReq} = 25'h0;
    extLevel = 8'h04;
    foreach (rows[i])
    begin
      boot(rows[i].pins);
      waitState(rows[i].mode == MODE_NORMAL ? ST_RUN : ST_HANDLER);
      chk("opMode", rows[i].mode, opMode);
      if (rows[i].mode != MODE_TEST)
      begin
        chk("flashWriteRestrict", rows[i].restr, flashWriteRestrict);
        chk("flashWriteDisable", rows[i].dis, flashWriteDisable);
      end
      $display("mode row %0d done", i);
    end
    boot(5'h00);
    waitState(ST_RUN);
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 1, err);
    chk("prdata", 0, rd);
    rdChk("periph", OFS_PERIPH, PERIPH_RST, 32'hFFFF_FFFF);
    rdChk("port1", OFS_PORT1, 32'h4, 32'hF);
    apb(1'b1, OFS_PERIPH, 32'h0);
    apb(1'b1, OFS_CONFIG_REG_ZERO, 32'h20);
    repeat (6) @(negedge sys_clk);
    chk("ctrlState", ST_RUN, ctrlState);
    apb(1'b1, OFS_PERIPH, PERIPH_RST);
    $display("register and ignore test done");
    for (int i = 0; i < RESUME_W; i++)
    begin
      apb(1'b1, OFS_CONFIG_REG_ZERO, 32'h1 << CONFIG_REG_ZERO_IDLE_BIT);
      waitState(ST_IDLE);
      resumeEvent <= 7'h01 << i;
      @(posedge sys_clk);
      resumeEvent <= 7'h00;
      waitState(ST_RUN);
      rdChk("resume flags", OFS_RESUME, 32'h1 << i, 32'h7F);
      apb(1'b1, OFS_RESUME, 32'h1 << i);
    end
    $display("resume test done");
    apb(1'b1, OFS_CONFIG_REG_ZERO, 32'h20);
    waitState(ST_IDLE);
    for (int j = 0; j <= IRQ_W; j++)
    begin
      irqRequest <= 10'h001 << (j % IRQ_W);
      @(posedge sys_clk);
      irqRequest <= 10'h000;
      waitState(ST_ISR);
      resumeEvent <= (j == IRQ_W) ? 7'h01 : 7'h00;
      @(posedge sys_clk);
      resumeEvent <= 7'h00;
      return_from_interrupt <= 1'b1;
      @(posedge sys_clk);
      return_from_interrupt <= 1'b0;
      waitState((j == IRQ_W) ? ST_RUN : ST_IDLE);
      if (j == 0)
      begin
        wakeReq <= 4'h2;
        @(posedge sys_clk);
        wakeReq <= 4'h0;
        repeat (6) @(posedge sys_clk);
        chk("ctrlState", ST_IDLE, ctrlState);
      end
    end
    wakeReq <= 4'h4;
    @(posedge sys_clk);
    wakeReq <= 4'h0;
    repeat (6) @(negedge sys_clk);
    chk("ctrlState", ST_RUN, ctrlState);
    rdChk("wake flags", OFS_WAKE, 32'h6, 32'h6);
    $display("idle and interrupt test done");
    apb(1'b1, OFS_EXTCFG, 32'h0000_0101);
    apb(1'b1, OFS_PERIPH, 32'h0000_017F);
    apb(1'b1, OFS_LFTIMER, 32'h0002_0003);
    for (int k = 0; k <= 4; k++)
    begin
      apb(1'b1, OFS_CONFIG_REG_ZERO, 32'h1 << CONFIG_REG_ZERO_POWER_DOWN_STATE_BIT);
      waitState(ST_POWER_DOWN);
      rdChk("wake flags", OFS_WAKE, 32'h0, 32'h1F);
      lfSeen = 1'b0;
      repeat (8) @(posedge sys_clk) lfSeen |= lfRxPowerOn;
      chk("lfRxPowerOn", 1, lfSeen);
      @(posedge sys_clk);
      if (k == 4)
        extLevel <= 8'h05;
      else
        wakeReq <= 4'h1 << k;
      @(posedge sys_clk);
      wakeReq <= 4'h0;
      waitState(ST_INIT);
      waitState(ST_RUN);
      if (k == 4)
        rdChk("ext wake flags", OFS_EXTWAKE, 32'h1, 32'hFF);
      else
        rdChk("wake flags", OFS_WAKE, 32'h1 << k, 32'hF);
    end
    $display("power down test done");
    watchdogElapsed <= 1'b1;
    @(posedge sys_clk);
    watchdogElapsed <= 1'b0;
    waitState(ST_INIT);
    waitState(ST_RUN);
    rdChk("wake flags", OFS_WAKE, 32'h1 << WAKE_WDG, 32'h1 << WAKE_WDG);
    $display("watchdog test done");
    summarize();
  end
endmodule
